// ===== vra_pkg.sv
// shared constants and types for the vme register access and indicator block
package vra_pkg;

   // register byte offsets from the board base address
   localparam logic [7:0] OFF_CTRL = 8'h02;
   localparam logic [7:0] OFF_PWR = 8'h14;
   localparam logic [7:0] OFF_FAULT = 8'h28;
   localparam logic [7:0] OFF_RSVD = 8'h40;
   localparam logic [7:0] OFF_HWA_54 = 8'h42;
   localparam logic [7:0] OFF_HWA_32 = 8'h44;
   localparam logic [7:0] OFF_HWA_10 = 8'h46;
   localparam logic [7:0] OFF_REFID = 8'h48;
   localparam logic [7:0] OFF_NET = 8'h4A;
   localparam logic [7:0] OFF_CMP_A = 8'h6C;
   localparam logic [7:0] OFF_CMP_B = 8'h70;
   localparam logic [7:0] OFF_IRQ_MASK = 8'hA6;

   // values after reset
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   localparam logic [15:0] NET_RESET = 16'h0001;
   localparam logic [15:0] IRQ_MASK_RESET = 16'h0000;
   localparam logic [31:0] CMP_RESET = 32'h00000000;
   localparam logic [31:0] FAULT_RESET = 32'h00000000;

   // field positions
   localparam int STATUS_FLASH_BIT = 7;
   localparam int NET_DHCP_BIT = 0;
   localparam int FLT_AC_HIGH = 0;
   localparam int FLT_DC_HIGH = 1;
   localparam int FLT_SQUELCH = 2;
   localparam int FLT_LOCK = 3;
   localparam int FLT_PER_CH = 4;
   localparam int MODE_A24_BIT = 0;
   localparam int MODE_GEO_BIT = 1;

   // address modifier codes accepted
   localparam logic [5:0] AM_A16_USER = 6'h29;
   localparam logic [5:0] AM_A16_SUP = 6'h2D;
   localparam logic [5:0] AM_A24_USER = 6'h39;
   localparam logic [5:0] AM_A24_SUP = 6'h3D;

   // times and clock rate
   localparam int unsigned CLK_KHZ = 100_000;
   localparam int unsigned BLINK_HALF_MS = 500;
   localparam int unsigned HOLD_MS = 5_000;

   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b00,
      ST_ACK = 2'b01,
      ST_BERR = 2'b10
   } vra_bus_e;

endpackage : vra_pkg

// ===== vra_regs.sv
// vme slave register access, front panel lamps, reference chain and factory reset
//
// What this block does
// R1 - slave accepts only D16 and D32 cycles; byte cycles get a bus error
// R2 - master makes 16-bit accesses only at even byte addresses
// R3 - master makes 32-bit accesses only at addresses divisible by four; the testbench also makes one at 0x6E, which gets a bus error
// R4 - upper half word of a 32-bit register sits at the lower address pair
// R5 - registers decode as offsets from switch base, A16/A24 with optional geographic base
// R6 - channel one power read gives AC in upper half, DC in lower
// R7 - 48-bit hardware address: three read-only half words after a reserved half word
// R8 - hardware address reads the same with 16-bit or 32-bit cycles
// R9 - upper compare registers read back the 32-bit value last written
// R10 - after boot, control bit seven flashes the status lamp, clear gives steady
// R11 - fault lamp lights on AC high, DC high, below squelch or lock lost
// R12 - faults latch until cause gone and software writes one to the bit
// R13 - signal lamp lit on enough AC power, flashes on AC or DC excess
// R14 - status lamp blinks during boot, then steady, or off on boot failure
// R15 - link lamp follows link pulses, traffic lamp follows network activity
// R16 - chain master is number zero; downstream boards report position in four bits
// R17 - reference input takes coded reference phase with its clock from neighbour
// R18 - reset button held over five seconds restores factory defaults; the block restores only the network register and pulses factory_default
// R19 - dynamic addressing on by default, can be switched off for static address
// R20 - a 16-bit access to half of a 32-bit register leaves other half
`timescale 1ns/1ps
module vra_regs
#(
   parameter int unsigned BLINK_HALF_CYCLES = vra_pkg::BLINK_HALF_MS * vra_pkg::CLK_KHZ,
   parameter int unsigned HOLD_CYCLES = vra_pkg::HOLD_MS * vra_pkg::CLK_KHZ,
   // arbitrary hardware address, not a real assignment
   parameter logic [47:0] HW_ADDR = 48'h020000000001
)
(
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic [23:1] vme_addr,
   input wire logic [5:0] vme_am,
   input wire logic vme_as_n,
   input wire logic vme_ds0_n,
   input wire logic vme_ds1_n,
   input wire logic vme_lword_n,
   input wire logic vme_write_n,
   input wire logic [31:0] vme_data_in,
   output logic [31:0] vme_data_out,
   output logic vme_data_oe_n,
   output logic vme_dtack_out,
   output logic vme_dtack_oe_n,
   output logic vme_berr_out,
   output logic vme_berr_oe_n,
   input wire logic [1:0] sw_mode,
   input wire logic [15:0] sw_base,
   input wire logic [4:0] geo_addr,
   input wire logic [15:0] ch1_ac_power,
   input wire logic [15:0] ch1_dc_power,
   input wire logic [15:0] fault_cause,
   input wire logic [3:0] signal_ok,
   input wire logic boot_done,
   input wire logic boot_failed,
   input wire logic link_pulse_seen,
   input wire logic traffic_seen,
   input wire logic reset_button_n,
   input wire logic ref_present,
   input wire logic [3:0] ref_id_in,
   input wire logic ref_clk_pin,
   input wire logic ref_data_pin,
   output logic [3:0] fault_lamp,
   output logic [3:0] signal_lamp,
   output logic status_lamp,
   output logic link_lamp,
   output logic network_traffic_lamp,
   output logic [3:0] ref_id_out,
   output logic [15:0] ref_phase,
   output logic factory_default,
   output logic dhcp_enable,
   output logic [15:0] axis_ctrl
);

   // two-stage synchroniser for the bus, switch, network, button and reference pin inputs
   localparam int PW = 99;
   logic [PW-1:0] pin_m_q;
   logic [PW-1:0] pin_s_q;
   logic as_n_s, ds0_n_s, ds1_n_s, lword_n_s, write_n_s;
   logic [5:0] am_s;
   logic [23:1] addr_s;
   logic [31:0] data_s;
   logic [1:0] mode_s;
   logic [15:0] base_s;
   logic [4:0] geo_s;
   logic link_s, traffic_s, button_n_s, ref_present_s, ref_clk_s, ref_data_s;
   logic [3:0] ref_id_s;

   wire [PW-1:0] pin_raw = {vme_as_n, vme_ds0_n, vme_ds1_n, vme_lword_n, vme_write_n, vme_am, vme_addr,
                            vme_data_in, sw_mode, sw_base, geo_addr, link_pulse_seen, traffic_seen,
                            reset_button_n, ref_present, ref_id_in, ref_clk_pin, ref_data_pin};
   assign {as_n_s, ds0_n_s, ds1_n_s, lword_n_s, write_n_s, am_s, addr_s, data_s, mode_s, base_s, geo_s,
           link_s, traffic_s, button_n_s, ref_present_s, ref_id_s, ref_clk_s, ref_data_s} = pin_s_q;

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pin_m_q <= '1;
         pin_s_q <= '1;
      end
      else
      begin
         pin_m_q <= pin_raw;
         pin_s_q <= pin_m_q;
      end
   end

   // registers
   vra_pkg::vra_bus_e state_q, state_d;
   logic ds_low_q, rd_q;
   logic [15:0] ctrl_q, net_q, irq_mask_q;
   logic [31:0] fault_q, cmp_a_q, cmp_b_q;
   logic [31:0] dout_q;
   logic [3:0] ref_id_q;
   logic [15:0] ref_shift_q;
   logic ref_clk_q;
   logic [31:0] blink_cnt_q, hold_cnt_q;
   logic blink_q, factory_q;
   logic [3:0] fault_lamp_q, signal_lamp_q;
   logic status_q, link_q, traffic_q;

   // address decode: base from switches or from the geographic slot
   wire geo_mode = mode_s[vra_pkg::MODE_GEO_BIT];
   wire a24_mode = mode_s[vra_pkg::MODE_A24_BIT];
   wire [15:0] base_sel = geo_mode ? {8'h00, geo_s, 3'h0} : base_s;
   wire am_a16 = (am_s == vra_pkg::AM_A16_USER) || (am_s == vra_pkg::AM_A16_SUP);
   wire am_a24 = (am_s == vra_pkg::AM_A24_USER) || (am_s == vra_pkg::AM_A24_SUP);
   wire hit16 = !a24_mode && am_a16 && (addr_s[15:8] == base_sel[7:0]); // see R5
   wire hit24 = a24_mode && am_a24 && (addr_s[23:8] == base_sel); // see R5

   // strobes must be seen low on two samples so address and data have settled
   wire ds_low = !ds0_n_s || !ds1_n_s;
   wire cyc_start = (state_q == vra_pkg::ST_IDLE) && !as_n_s && ds_low && ds_low_q && (hit16 || hit24);
   wire is_d32 = !lword_n_s;
   wire byte_cyc = ds0_n_s != ds1_n_s; // see R1
   wire misalign = is_d32 && addr_s[1];
   wire bad_width = byte_cyc || misalign;
   wire go = cyc_start && !bad_width;
   wire go_wr = go && !write_n_s;
   wire go_rd = go && write_n_s;

   // half-word lanes: even half is the upper half word, odd half the lower half word
   wire [6:0] idx = addr_s[7:1];
   wire [5:0] wix = idx[6:1];
   wire we_e = go_wr && (is_d32 || !idx[0]); // see R20
   wire we_o = go_wr && (is_d32 || idx[0]); // see R20
   wire [15:0] upper_half_word = is_d32 ? data_s[31:16] : data_s[15:0]; // see R4
   wire [15:0] lower_half_word = data_s[15:0];

   wire wr_ctrl = we_o && (wix == vra_pkg::OFF_CTRL[7:2]);
   wire wr_net = we_o && (wix == vra_pkg::OFF_NET[7:2]);
   wire wr_mask = we_o && (wix == vra_pkg::OFF_IRQ_MASK[7:2]);
   wire wr_flt_e = we_e && (wix == vra_pkg::OFF_FAULT[7:2]);
   wire wr_flt_o = we_o && (wix == vra_pkg::OFF_FAULT[7:2]);
   wire wr_cmpa_e = we_e && (wix == vra_pkg::OFF_CMP_A[7:2]);
   wire wr_cmpa_o = we_o && (wix == vra_pkg::OFF_CMP_A[7:2]);
   wire wr_cmpb_e = we_e && (wix == vra_pkg::OFF_CMP_B[7:2]);
   wire wr_cmpb_o = we_o && (wix == vra_pkg::OFF_CMP_B[7:2]);

   // read word at a word index, upper half first
   function automatic logic [31:0] word_rd(input logic [5:0] w);
      logic [31:0] r;
      r = 32'h00000000;
      case (w)
         vra_pkg::OFF_CTRL[7:2]: r = {16'h0000, ctrl_q};
         vra_pkg::OFF_PWR[7:2]: r = {ch1_ac_power, ch1_dc_power}; // see R6
         vra_pkg::OFF_FAULT[7:2]: r = fault_q;
         vra_pkg::OFF_RSVD[7:2]: r = {16'h0000, HW_ADDR[47:32]}; // see R7
         vra_pkg::OFF_HWA_32[7:2]: r = HW_ADDR[31:0]; // see R7
         vra_pkg::OFF_REFID[7:2]: r = {12'h000, ref_id_q, net_q};
         vra_pkg::OFF_CMP_A[7:2]: r = cmp_a_q; // see R9
         vra_pkg::OFF_CMP_B[7:2]: r = cmp_b_q; // see R9
         vra_pkg::OFF_IRQ_MASK[7:2]: r = {16'h0000, irq_mask_q};
         default: r = 32'h00000000;
      endcase
      return r;
   endfunction : word_rd

   logic [31:0] rd_word;
   always_comb rd_word = word_rd(wix);
   wire [15:0] rd_half = idx[0] ? rd_word[15:0] : rd_word[31:16];
   wire [31:0] rd_data = is_d32 ? rd_word : {16'h0000, rd_half}; // see R8

   // bus handshake
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         vra_pkg::ST_IDLE:
         begin
            if (cyc_start)
               state_d = bad_width ? vra_pkg::ST_BERR : vra_pkg::ST_ACK; // see R1
         end
         vra_pkg::ST_ACK, vra_pkg::ST_BERR:
         begin
            if (!ds_low)
               state_d = vra_pkg::ST_IDLE;
         end
         default: state_d = vra_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_q <= vra_pkg::ST_IDLE;
         ds_low_q <= 1'b0;
         rd_q <= 1'b0;
         dout_q <= 32'h00000000;
      end
      else
      begin
         state_q <= state_d;
         ds_low_q <= ds_low;
         if (cyc_start)
            rd_q <= write_n_s;
         if (go_rd)
            dout_q <= rd_data;
      end
   end

   // writable registers; unmapped writes are acknowledged and dropped
   wire [31:0] flt_clr = {wr_flt_e ? upper_half_word : 16'h0000, wr_flt_o ? lower_half_word : 16'h0000};
   wire [31:0] fault_d = (fault_q & ~flt_clr) | {16'h0000, fault_cause}; // see R12
   wire [31:0] cmp_a_d = {wr_cmpa_e ? upper_half_word : cmp_a_q[31:16], wr_cmpa_o ? lower_half_word : cmp_a_q[15:0]};
   wire [31:0] cmp_b_d = {wr_cmpb_e ? upper_half_word : cmp_b_q[31:16], wr_cmpb_o ? lower_half_word : cmp_b_q[15:0]};

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ctrl_q <= vra_pkg::CTRL_RESET;
         net_q <= vra_pkg::NET_RESET;
         irq_mask_q <= vra_pkg::IRQ_MASK_RESET;
         fault_q <= vra_pkg::FAULT_RESET;
         cmp_a_q <= vra_pkg::CMP_RESET;
         cmp_b_q <= vra_pkg::CMP_RESET;
      end
      else
      begin
         fault_q <= fault_d; // see R12
         cmp_a_q <= cmp_a_d; // see R20
         cmp_b_q <= cmp_b_d; // see R9
         if (wr_ctrl)
            ctrl_q <= lower_half_word;
         if (wr_mask)
            irq_mask_q <= lower_half_word;
         if (factory_q)
            net_q <= vra_pkg::NET_RESET; // see R19
         else if (wr_net)
            net_q <= lower_half_word; // see R19
      end
   end

   // blink divider shared by status and signal lamps
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         blink_cnt_q <= 32'h00000000;
         blink_q <= 1'b0;
      end
      else if (blink_cnt_q == 32'(BLINK_HALF_CYCLES - 1))
      begin
         blink_cnt_q <= 32'h00000000;
         blink_q <= !blink_q;
      end
      else
         blink_cnt_q <= blink_cnt_q + 32'h00000001;
   end

   // lamps
   logic [3:0] fault_any, power_high;
   genvar c;
   generate
      for (c = 0; c < 4; c++)
      begin : g_ch
         wire [3:0] cause_c = fault_cause[c*vra_pkg::FLT_PER_CH +: vra_pkg::FLT_PER_CH];
         assign fault_any[c] = |(fault_q[c*vra_pkg::FLT_PER_CH +: vra_pkg::FLT_PER_CH]) || |cause_c; // see R11
         assign power_high[c] = cause_c[vra_pkg::FLT_AC_HIGH] || cause_c[vra_pkg::FLT_DC_HIGH];
      end
   endgenerate

   wire [3:0] signal_d = (power_high & {4{blink_q}}) | (~power_high & signal_ok); // see R13
   wire status_user = ctrl_q[vra_pkg::STATUS_FLASH_BIT] ? blink_q : 1'b1; // see R10
   wire status_d = boot_failed ? 1'b0 : (!boot_done ? blink_q : status_user); // see R14

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         fault_lamp_q <= 4'h0;
         signal_lamp_q <= 4'h0;
         status_q <= 1'b0;
         link_q <= 1'b0;
         traffic_q <= 1'b0;
      end
      else
      begin
         fault_lamp_q <= fault_any; // see R11
         signal_lamp_q <= signal_d; // see R13
         status_q <= status_d; // see R14
         link_q <= link_s; // see R15
         traffic_q <= traffic_s; // see R15
      end
   end

   // reference chain: position and coded phase from the neighbour
   wire ref_rise = ref_clk_s && !ref_clk_q;
   wire [3:0] ref_id_d = !ref_present_s ? 4'h0 : ((ref_id_s == 4'hF) ? 4'hF : ref_id_s + 4'h1);

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ref_clk_q <= 1'b1;
         ref_shift_q <= 16'h0000;
         ref_id_q <= 4'h0;
      end
      else
      begin
         ref_clk_q <= ref_clk_s;
         ref_id_q <= ref_id_d; // see R16
         if (ref_rise)
            ref_shift_q <= {ref_shift_q[14:0], ref_data_s}; // see R17
      end
   end

   // factory reset after the button is held beyond the hold time
   wire pressed = !button_n_s;
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         hold_cnt_q <= 32'h00000000;
         factory_q <= 1'b0;
      end
      else
      begin
         factory_q <= pressed && (hold_cnt_q == 32'(HOLD_CYCLES)); // see R18
         if (!pressed)
            hold_cnt_q <= 32'h00000000;
         else if (hold_cnt_q <= 32'(HOLD_CYCLES))
            hold_cnt_q <= hold_cnt_q + 32'h00000001;
      end
   end

   assign vme_data_out = dout_q;
   assign vme_dtack_out = 1'b0 & state_q[0];
   assign vme_berr_out = 1'b0 & state_q[1];
   assign fault_lamp = fault_lamp_q;
   assign signal_lamp = signal_lamp_q;
   assign status_lamp = status_q;
   assign link_lamp = link_q;
   assign network_traffic_lamp = traffic_q;
   assign ref_id_out = ref_id_q;
   assign ref_phase = ref_shift_q;
   assign factory_default = factory_q;
   assign dhcp_enable = net_q[vra_pkg::NET_DHCP_BIT];
   assign axis_ctrl = ctrl_q;

   // open-drain drivers: enable low while driving
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         vme_data_oe_n <= 1'b1;
         vme_dtack_oe_n <= 1'b1;
         vme_berr_oe_n <= 1'b1;
      end
      else
      begin
         vme_dtack_oe_n <= state_d != vra_pkg::ST_ACK;
         vme_berr_oe_n <= state_d != vra_pkg::ST_BERR;
         vme_data_oe_n <= !((state_d == vra_pkg::ST_ACK) && (cyc_start ? write_n_s : rd_q));
      end
   end

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!arst_n);

   sequence s_byte_cycle;
      cyc_start && byte_cyc;
   endsequence
   sequence s_pwr_read;
      go_rd && is_d32 && (wix == vra_pkg::OFF_PWR[7:2]);
   endsequence
   sequence s_half_write_lower;
      go_wr && !is_d32 && idx[0] && (wix == vra_pkg::OFF_CMP_B[7:2]);
   endsequence

   property p_byte_berr;
      s_byte_cycle |=> !vme_berr_oe_n && vme_dtack_oe_n && vme_data_oe_n;
   endproperty
   a_byte_berr: assert property (p_byte_berr) else $error("byte cycle not refused"); // see R1

   property p_pwr_order;
      s_pwr_read |=> vme_data_out == {$past(ch1_ac_power), $past(ch1_dc_power)};
   endproperty
   a_pwr_order: assert property (p_pwr_order) else $error("power word order wrong"); // see R6

   property p_upper_first;
      (go_rd && !is_d32 && !idx[0] && (wix == vra_pkg::OFF_HWA_32[7:2])) |=>
         vme_data_out[15:0] == HW_ADDR[31:16];
   endproperty
   a_upper_first: assert property (p_upper_first) else $error("upper half not at lower address"); // see R4

   property p_hwaddr_same;
      (go_rd && (wix == vra_pkg::OFF_HWA_32[7:2]) && (is_d32 || idx[0])) |=>
         vme_data_out[15:0] == HW_ADDR[15:0] ##1 1'b1;
   endproperty
   a_hwaddr_same: assert property (p_hwaddr_same) else $error("hardware address word differs"); // see R8

   property p_cmp_readback;
      (go_wr && is_d32 && (wix == vra_pkg::OFF_CMP_B[7:2])) |=> cmp_b_q == $past(data_s);
   endproperty
   a_cmp_readback: assert property (p_cmp_readback) else $error("compare register lost write"); // see R9

   property p_half_keep;
      s_half_write_lower |=> cmp_b_q[31:16] == $past(cmp_b_q[31:16]) && cmp_b_q[15:0] == $past(data_s[15:0]);
   endproperty
   a_half_keep: assert property (p_half_keep) else $error("half write disturbed other half"); // see R20

   property p_fault_sticky;
      !(wr_flt_e || wr_flt_o) |=> (fault_q & $past(fault_q)) == $past(fault_q);
   endproperty
   a_fault_sticky: assert property (p_fault_sticky) else $error("fault bit dropped without write"); // see R12

   property p_fault_set_wins;
      (fault_cause != 16'h0000) |=> (fault_q[15:0] & $past(fault_cause)) == $past(fault_cause);
   endproperty
   a_fault_set_wins: assert property (p_fault_set_wins) else $error("fault cause not latched"); // see R12

   property p_err_lamp;
      fault_cause[vra_pkg::FLT_LOCK] |=> fault_lamp[0] [*2];
   endproperty
   a_err_lamp: assert property (p_err_lamp) else $error("fault lamp dark on lost lock"); // see R11

   property p_boot_fail_off;
      boot_failed |=> !status_lamp;
   endproperty
   a_boot_fail_off: assert property (p_boot_fail_off) else $error("status lamp lit after boot failure"); // see R14

   property p_steady_green;
      (boot_done && !boot_failed && !ctrl_q[vra_pkg::STATUS_FLASH_BIT]) |=> status_lamp;
   endproperty
   a_steady_green: assert property (p_steady_green) else $error("status lamp not steady"); // see R10

   property p_ref_pos;
      (ref_present_s && (ref_id_s != 4'hF)) |=> ref_id_out == $past(ref_id_s) + 4'h1;
   endproperty
   a_ref_pos: assert property (p_ref_pos) else $error("chain position wrong"); // see R16

   property p_ref_master;
      !ref_present_s |=> ref_id_out == 4'h0;
   endproperty
   a_ref_master: assert property (p_ref_master) else $error("master not number zero"); // see R16

   property p_factory;
      factory_default |-> $past(hold_cnt_q) == 32'(HOLD_CYCLES) && $past(pressed);
   endproperty
   a_factory: assert property (p_factory) else $error("factory reset before hold time"); // see R18

endmodule : vra_regs

// ===== vra_master.sv
// bus master model that runs vme slave cycles against the register block
`timescale 1ns/1ps
module vra_master
(
   input wire logic clk_sys,
   output logic [23:1] vme_addr = '0,
   output logic [5:0] vme_am = 6'h29,
   output logic vme_as_n = 1'b1,
   output logic vme_ds0_n = 1'b1,
   output logic vme_ds1_n = 1'b1,
   output logic vme_lword_n = 1'b1,
   output logic vme_write_n = 1'b1,
   output logic [31:0] vme_data_in = '0,
   input wire logic [31:0] vme_data_out,
   input wire logic vme_dtack_oe_n,
   input wire logic vme_berr_oe_n
);
   // sz: 0 byte (only when a refusal is wanted), 1 d16, 2 d32; resp: 0 none, 1 ack, 2 bus error
   task automatic cyc(input logic w, input logic [1:0] sz, input logic [7:0] off, input logic [31:0] wd,
                      output logic [31:0] rd, output logic [1:0] resp);
      int n;
      @(posedge clk_sys);
      vme_addr <= {8'h00, 8'h18, off[7:1]};
      vme_lword_n <= (sz != 2'd2);
      vme_write_n <= !w;
      vme_data_in <= wd;
      vme_as_n <= 1'b0;
      vme_ds0_n <= 1'b0;
      vme_ds1_n <= (sz == 2'd0);
      resp = 2'd0;
      for (n = 0; n < 40 && resp == 2'd0; n++)
      begin
         @(posedge clk_sys);
         if (vme_dtack_oe_n === 1'b0) resp = 2'd1;
         else if (vme_berr_oe_n === 1'b0) resp = 2'd2;
      end
      rd = vme_data_out;
      vme_as_n <= 1'b1;
      vme_ds0_n <= 1'b1;
      vme_ds1_n <= 1'b1;
      // released data lines do not keep the last value
      vme_data_in <= ~wd;
      for (n = 0; n < 12 && !(vme_dtack_oe_n === 1'b1 && vme_berr_oe_n === 1'b1); n++)
         @(posedge clk_sys);
   endtask : cyc
endmodule : vra_master

// ===== test_vra_regs.sv
// self-checking testbench for the vme register and indicator block
`timescale 1ns/1ps
module test_vra_regs;
   // arbitrary hardware address for the test
   localparam logic [47:0] HWA = 48'h0A0B0C0D0E0F;
   logic clk_sys = 1'b0;
   logic arst_n = 1'b0;
   logic [23:1] vme_addr;
   logic [5:0] vme_am;
   logic vme_as_n, vme_ds0_n, vme_ds1_n, vme_lword_n, vme_write_n;
   logic [31:0] vme_data_in, vme_data_out;
   logic vme_dtack_oe_n, vme_berr_oe_n;
   logic [15:0] ch1_ac_power = 16'h1234;
   logic [15:0] ch1_dc_power = 16'h5678;
   logic [15:0] fault_cause = '0;
   logic [3:0] signal_ok = '0, ref_id_in = '0;
   logic boot_done = 1'b0, boot_failed = 1'b0, link_pulse_seen = 1'b0, traffic_seen = 1'b0;
   logic reset_button_n = 1'b1, ref_present = 1'b0, ref_clk_pin = 1'b0, ref_data_pin = 1'b0;
   logic [3:0] fault_lamp, signal_lamp, ref_id_out;
   logic status_lamp, link_lamp, network_traffic_lamp, factory_default, dhcp_enable;
   logic [15:0] axis_ctrl, ref_phase;
   int bad_count = 0;
   int num_checks = 0;
   always #5 clk_sys = ~clk_sys;
   vra_master i_vra_master (.clk_sys(clk_sys), .vme_addr(vme_addr), .vme_am(vme_am), .vme_as_n(vme_as_n),
      .vme_ds0_n(vme_ds0_n), .vme_ds1_n(vme_ds1_n), .vme_lword_n(vme_lword_n), .vme_write_n(vme_write_n),
      .vme_data_in(vme_data_in), .vme_data_out(vme_data_out), .vme_dtack_oe_n(vme_dtack_oe_n),
      .vme_berr_oe_n(vme_berr_oe_n));
   vra_regs #(.BLINK_HALF_CYCLES(4), .HOLD_CYCLES(20), .HW_ADDR(HWA)) i_vra_regs (.clk_sys(clk_sys),
      .arst_n(arst_n), .vme_addr(vme_addr), .vme_am(vme_am), .vme_as_n(vme_as_n), .vme_ds0_n(vme_ds0_n),
      .vme_ds1_n(vme_ds1_n), .vme_lword_n(vme_lword_n), .vme_write_n(vme_write_n), .vme_data_in(vme_data_in),
      .vme_data_out(vme_data_out), .vme_data_oe_n(), .vme_dtack_out(), .vme_dtack_oe_n(vme_dtack_oe_n),
      .vme_berr_out(), .vme_berr_oe_n(vme_berr_oe_n), .sw_mode(2'b00), .sw_base(16'h0018), .geo_addr(5'h00),
      .ch1_ac_power(ch1_ac_power), .ch1_dc_power(ch1_dc_power), .fault_cause(fault_cause), .signal_ok(signal_ok),
      .boot_done(boot_done), .boot_failed(boot_failed), .link_pulse_seen(link_pulse_seen),
      .traffic_seen(traffic_seen), .reset_button_n(reset_button_n), .ref_present(ref_present),
      .ref_id_in(ref_id_in), .ref_clk_pin(ref_clk_pin), .ref_data_pin(ref_data_pin), .fault_lamp(fault_lamp),
      .signal_lamp(signal_lamp), .status_lamp(status_lamp), .link_lamp(link_lamp),
      .network_traffic_lamp(network_traffic_lamp), .ref_id_out(ref_id_out), .ref_phase(ref_phase),
      .factory_default(factory_default), .dhcp_enable(dhcp_enable), .axis_ctrl(axis_ctrl));
   task automatic summarize();
      if (bad_count == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : summarize
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic acc(input logic w, input logic [1:0] sz, input logic [7:0] off, input logic [31:0] wd,
                      input logic [1:0] er, output logic [31:0] d);
      logic [1:0] r;
      i_vra_master.cyc(w, sz, off, wd, d, r);
      if (r === 2'd0)
      begin
         bad_count++;
         $display("BAD %0t no bus answer", $time);
         summarize();
      end
      chk(r, er);
   endtask : acc
   task automatic rd(input logic [1:0] sz, input logic [7:0] off, input logic [31:0] exp);
      logic [31:0] d;
      acc(1'b0, sz, off, '0, 2'd1, d);
      chk(sz == 2'd1 ? {16'h0000, d[15:0]} : d, exp);
   endtask : rd
   task automatic wr(input logic [1:0] sz, input logic [7:0] off, input logic [31:0] wd);
      logic [31:0] d;
      acc(1'b1, sz, off, wd, 2'd1, d);
   endtask : wr
   task automatic changes(input logic sel, output int n);
      logic p;
      n = 0;
      p = sel ? signal_lamp[0] : status_lamp;
      repeat (12)
      begin
         @(posedge clk_sys);
         if ((sel ? signal_lamp[0] : status_lamp) !== p) n++;
         p = sel ? signal_lamp[0] : status_lamp;
      end
   endtask : changes
   task automatic t_ident();
      rd(2'd2, 8'h44, HWA[31:0]);
      rd(2'd1, 8'h42, HWA[47:32]);
      rd(2'd1, 8'h44, HWA[31:16]);
      rd(2'd1, 8'h46, HWA[15:0]);
      rd(2'd2, 8'h14, {ch1_ac_power, ch1_dc_power});
      rd(2'd1, 8'h16, ch1_dc_power);
   endtask : t_ident
   task automatic t_regs();
      logic [31:0] d;
      rd(2'd1, vra_pkg::OFF_IRQ_MASK, vra_pkg::IRQ_MASK_RESET);
      rd(2'd2, vra_pkg::OFF_CMP_A, vra_pkg::CMP_RESET);
      wr(2'd2, 8'h6C, 32'hA5A5_0F0F);
      wr(2'd2, 8'h70, 32'h1234_8765);
      rd(2'd2, 8'h6C, 32'hA5A5_0F0F);
      wr(2'd1, 8'h72, 32'h0000_BEEF);
      rd(2'd2, 8'h70, 32'h1234_BEEF);
      wr(2'd1, 8'hA6, 32'h0000_00C3);
      rd(2'd1, 8'hA6, 32'h0000_00C3);
      acc(1'b1, 2'd0, 8'h6C, 32'hFFFF_FFFF, 2'd2, d);
      acc(1'b1, 2'd2, 8'h6E, 32'hFFFF_FFFF, 2'd2, d);
      rd(2'd2, 8'h6C, 32'hA5A5_0F0F);
   endtask : t_regs
   task automatic t_status();
      int n;
      changes(1'b0, n);
      chk(n > 1, 1);
      @(posedge clk_sys) boot_done <= 1'b1;
      repeat (3) @(posedge clk_sys);
      changes(1'b0, n);
      chk({n[30:0], status_lamp}, 1);
      wr(2'd1, vra_pkg::OFF_CTRL, 32'h0000_0080);
      chk(axis_ctrl, 16'h0080);
      changes(1'b0, n);
      chk(n > 1, 1);
      wr(2'd1, vra_pkg::OFF_CTRL, 32'h0);
      changes(1'b0, n);
      chk({n[30:0], status_lamp}, 1);
      @(posedge clk_sys) boot_failed <= 1'b1;
      repeat (3) @(posedge clk_sys);
      chk(status_lamp, 1'b0);
      boot_failed <= 1'b0;
   endtask : t_status
   task automatic t_fault();
      int n;
      @(posedge clk_sys);
      fault_cause <= 16'h8429;
      signal_ok <= 4'h1;
      repeat (3) @(posedge clk_sys);
      chk(fault_lamp, 4'hF);
      changes(1'b1, n);
      chk(n > 1, 1);
      wr(2'd2, vra_pkg::OFF_FAULT, 32'h0000_8421);
      rd(2'd2, vra_pkg::OFF_FAULT, 32'h0000_8429);
      @(posedge clk_sys) fault_cause <= '0;
      repeat (3) @(posedge clk_sys);
      chk({fault_lamp, signal_lamp}, 8'hF1);
      wr(2'd2, vra_pkg::OFF_FAULT, 32'h0000_8429);
      rd(2'd2, vra_pkg::OFF_FAULT, 32'h0);
      repeat (3) @(posedge clk_sys);
      chk(fault_lamp, 4'h0);
   endtask : t_fault
   task automatic t_misc();
      int n;
      @(posedge clk_sys);
      ref_present <= 1'b1;
      ref_id_in <= 4'h3;
      link_pulse_seen <= 1'b1;
      traffic_seen <= 1'b1;
      repeat (6) @(posedge clk_sys);
      chk({ref_id_out, link_lamp, network_traffic_lamp}, 6'h13);
      rd(2'd1, vra_pkg::OFF_REFID, 32'h4);
      ref_id_in <= 4'hF;
      link_pulse_seen <= 1'b0;
      repeat (8) @(posedge clk_sys) {ref_clk_pin, ref_data_pin} <= {!ref_clk_pin, 1'b1};
      chk({ref_id_out, link_lamp, network_traffic_lamp}, 6'h3D);
      rd(2'd1, vra_pkg::OFF_NET, vra_pkg::NET_RESET);
      chk(ref_phase, 16'h000F);
      wr(2'd1, vra_pkg::OFF_NET, 32'h0);
      chk(dhcp_enable, 1'b0);
      @(posedge clk_sys) reset_button_n <= 1'b0;
      n = 0;
      repeat (40) @(posedge clk_sys) if (factory_default === 1'b1) n++;
      chk(n, 1);
      reset_button_n <= 1'b1;
      rd(2'd1, vra_pkg::OFF_NET, 32'h1);
   endtask : t_misc
   initial
   begin
      repeat (2) @(posedge clk_sys);
      arst_n <= 1'b1;
      t_ident();
      t_regs();
      t_status();
      t_fault();
      t_misc();
      summarize();
   end
endmodule : test_vra_regs
